/* design/lpodc_pkg.sv */
// Constants for the front-panel object display controller
package lpodc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_MAIN_ADDR = 8'h04;
  localparam logic [7:0] OFS_BUS_ADDR  = 8'h08;
  localparam logic [7:0] OFS_DCS       = 8'h0c;
  localparam logic [7:0] OFS_IDX       = 8'h10;
  localparam logic [7:0] OFS_FIRST     = 8'h14;
  localparam logic [7:0] OFS_STAT      = 8'h18;
  localparam logic [1:0] TBL_PAGE      = 2'h1;

  // ----------------------------------------------------------------
  // Control register bits
  // ----------------------------------------------------------------
  localparam int CB_MAIN_EN  = 0;
  localparam int CB_BUS_EN   = 1;
  localparam int CB_BAT_INH  = 2;
  localparam int CB_WORD_EN  = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;

  // ----------------------------------------------------------------
  // Display control/status word fields
  // ----------------------------------------------------------------
  localparam int DCS_HEX  = 4;
  localparam int DCS_DOWN = 5;
  localparam int DCS_LO   = 6;
  localparam int DCS_HI   = 7;
  localparam int DCS_ERR  = 15;
  localparam logic [15:0] DCS_RST   = 16'h00d0;
  localparam logic [15:0] IDX_RST   = 16'h0f00;
  localparam logic [15:0] FIRST_RST = 16'h0000;
  localparam logic [15:0] MAIN_ADDR_RST = 16'h001a;
  localparam logic [15:0] BUS_ADDR_RST  = 16'h001b;
  localparam logic [1:0]  BYTE_LO  = 2'h1;
  localparam logic [1:0]  BYTE_HI  = 2'h2;
  localparam logic [1:0]  BYTE_ALT = 2'h3;
  localparam logic [1:0]  BYTE_BAD = 2'h0;

  // ----------------------------------------------------------------
  // Object type codes and bit group limits
  // ----------------------------------------------------------------
  localparam logic [3:0] OBJ_IWORD = 4'h0;
  localparam logic [3:0] OBJ_SWORD = 4'h1;
  localparam logic [3:0] OBJ_KWORD = 4'h2;
  localparam logic [3:0] OBJ_IBIT  = 4'h8;
  localparam logic [3:0] OBJ_SBIT  = 4'h9;
  localparam logic [3:0] OBJ_XBIT  = 4'ha;
  localparam logic [3:0] OBJ_RIO   = 4'hb;
  localparam logic [7:0] IBIT_LAST = 8'h03;
  localparam logic [7:0] SBIT_LAST = 8'h01;
  localparam logic [7:0] XBIT_LAST = 8'h01;
  localparam logic [8:0] TBL_LAST  = 9'h00f;

  // ----------------------------------------------------------------
  // Bus and timing
  // ----------------------------------------------------------------
  localparam logic [2:0] SZ_WORD = 3'h2;
  localparam int ALT_TIME_MS = 2;
  localparam int ALT_TIME_S  = ALT_TIME_MS;
  localparam int CLK_MHZ     = 200;
  localparam int ALT_CYCLES_DFLT = ALT_TIME_S * 1000 * 1000 * CLK_MHZ / 1000 * 1000;

  typedef enum logic [1:0] {
    PH_LOW  = 2'b01,
    PH_HIGH = 2'b10
  } lpodc_phase_t;

endpackage : lpodc_pkg

/* design/lpodc_top.sv */
// Front-panel object display controller with AHB-Lite register slave
//
// Implementation choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

module lpodc_top
  import lpodc_pkg::*;
#(
  parameter int unsigned ALT_CYCLES = ALT_CYCLES_DFLT
) (
  // Clock and reset
  input  wire  logic        mclk,
  input  wire  logic        arst_n,
  // AHB-Lite slave
  input  wire  logic        hsel,
  input  wire  logic [31:0] haddr,
  input  wire  logic [1:0]  htrans,
  input  wire  logic        hwrite,
  input  wire  logic [2:0]  hsize,
  input  wire  logic [31:0] hwdata,
  input  wire  logic        hready,
  output var   logic        hreadyout,
  output var   logic [31:0] hrdata,
  output var   logic        hresp,
  // Buttons, inputs and battery
  input  wire  logic        mainButton,
  input  wire  logic        busmodButton,
  input  wire  logic [255:0] discreteIn,
  input  wire  logic        batteryFault,
  // LEDs and events
  output var   logic        batteryLed,
  output var   logic        wordModeLed,
  output var   logic [31:0] panel0,
  output var   logic [31:0] panel1,
  output var   logic [31:0] panel2,
  output var   logic        busmodStep,
  output var   logic [15:0] objWordAddr
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rstMeta_r;
  logic rstN_r;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_r <= 1'b0;
      rstN_r    <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstN_r    <= rstMeta_r;
    end
  end

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [7:0] objLimit(input logic [3:0] t, input logic [7:0] mx);
    unique case (t)
      OBJ_IBIT: return IBIT_LAST;
      OBJ_SBIT: return SBIT_LAST;
      OBJ_XBIT: return XBIT_LAST;
      default:  return mx;
    endcase
  endfunction : objLimit

  function automatic logic [7:0] wrapAdd(input logic [7:0] s0, input logic [1:0] k,
                                         input logic [7:0] mx);
    logic [7:0] s;
    s = s0;
    for (int i = 0; i < 3; i++) begin
      if (i < int'(k)) begin
        s = (s >= mx) ? 8'h00 : s + 8'h01;
      end
    end
    return s;
  endfunction : wrapAdd

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic [3:0]  ctrl_r;
  logic [15:0] mainAddr_r;
  logic [15:0] busAddr_r;
  logic [15:0] dcs_r;
  logic [7:0]  cur_r;
  logic [7:0]  max_r;
  logic [15:0] first_r;
  logic        errFlag_r;
  logic [15:0] tbl_r [16];
  logic        wrPend_r;
  logic [7:0]  wrAddr_r;
  logic [31:0] rdVal;
  logic        addrPh;

  function automatic logic wrHit(input logic [7:0] ofs);
    return wrPend_r && (wrAddr_r == ofs);
  endfunction : wrHit

  assign addrPh = hsel && htrans[1] && hready;

  always_ff @(posedge mclk or negedge rstN_r) begin
    if (!rstN_r) begin
      wrPend_r  <= 1'b0;
      wrAddr_r  <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wrPend_r  <= addrPh && hwrite && (hsize == SZ_WORD) && (haddr[31:8] == 24'h00_0000);
      wrAddr_r  <= haddr[7:0];
      hrdata    <= (addrPh && !hwrite) ? rdVal : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Unmapped addresses read as zero
  always_comb begin
    rdVal = 32'h0000_0000;
    if (haddr[31:8] == 24'h00_0000) begin
      if (haddr[7:6] == TBL_PAGE) begin
        rdVal = {16'h0000, tbl_r[haddr[5:2]]};
      end else begin
        unique case (haddr[7:0])
          OFS_CTRL:      rdVal = {28'h000_0000, ctrl_r};
          OFS_MAIN_ADDR: rdVal = {16'h0000, mainAddr_r};
          OFS_BUS_ADDR:  rdVal = {16'h0000, busAddr_r};
          OFS_DCS:       rdVal = {16'h0000, errFlag_r, dcs_r[14:0]};
          OFS_IDX:       rdVal = {16'h0000, max_r, cur_r};
          OFS_FIRST:     rdVal = {16'h0000, first_r};
          OFS_STAT:      rdVal = {30'h0000_0000, batteryFault, ctrl_r[CB_WORD_EN]};
          default:       rdVal = 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstN_r) begin
    if (!rstN_r) begin
      ctrl_r     <= CTRL_RST;
      mainAddr_r <= MAIN_ADDR_RST;
      busAddr_r  <= BUS_ADDR_RST;
      dcs_r      <= DCS_RST;
      first_r    <= FIRST_RST;
    end else begin
      if (wrHit(OFS_CTRL))      ctrl_r     <= hwdata[3:0];
      if (wrHit(OFS_MAIN_ADDR)) mainAddr_r <= hwdata[15:0];
      if (wrHit(OFS_BUS_ADDR))  busAddr_r  <= hwdata[15:0];
      if (wrHit(OFS_DCS))       dcs_r      <= hwdata[15:0];
      if (wrHit(OFS_FIRST))     first_r    <= hwdata[15:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (wrPend_r && (wrAddr_r[7:6] == TBL_PAGE)) begin
      tbl_r[wrAddr_r[5:2]] <= hwdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Push sources and step events
  // ----------------------------------------------------------------
  logic mainSrc;
  logic busSrc;
  logic mainLvl_r;
  logic busLvl_r;
  logic mainStep;

  assign mainSrc = ctrl_r[CB_MAIN_EN] ? discreteIn[mainAddr_r[7:0]] : mainButton;
  assign busSrc  = ctrl_r[CB_BUS_EN] ? discreteIn[busAddr_r[7:0]] : busmodButton;
  assign mainStep = mainSrc && !mainLvl_r;

  always_ff @(posedge mclk or negedge rstN_r) begin
    if (!rstN_r) begin
      mainLvl_r  <= 1'b0;
      busLvl_r   <= 1'b0;
      busmodStep <= 1'b0;
    end else begin
      mainLvl_r  <= mainSrc;
      busLvl_r   <= busSrc;
      busmodStep <= busSrc && !busLvl_r;
    end
  end

  // ----------------------------------------------------------------
  // Index word
  // ----------------------------------------------------------------
  logic [7:0] limit;
  logic [7:0] stepIdx;
  logic       wordEn;

  assign wordEn = ctrl_r[CB_WORD_EN];
  assign limit  = objLimit(dcs_r[3:0], max_r);
  assign stepIdx = dcs_r[DCS_DOWN] ? ((cur_r == 8'h00) ? limit : cur_r - 8'h01)
                                   : ((cur_r >= limit) ? 8'h00 : cur_r + 8'h01);

  // Software write wins over a coincident press
  always_ff @(posedge mclk or negedge rstN_r) begin
    if (!rstN_r) begin
      cur_r <= IDX_RST[7:0];
      max_r <= IDX_RST[15:8];
    end else if (wrHit(OFS_IDX)) begin
      cur_r <= hwdata[7:0];
      max_r <= hwdata[15:8];
    end else if (wordEn && mainStep) begin
      cur_r <= stepIdx;
    end
  end

  // ----------------------------------------------------------------
  // Error detection
  // ----------------------------------------------------------------
  logic badType;
  logic errNow;

  assign badType = !(dcs_r[3:0] inside {OBJ_IWORD, OBJ_SWORD, OBJ_KWORD, OBJ_IBIT,
                                         OBJ_SBIT, OBJ_XBIT, OBJ_RIO});
  assign errNow = (dcs_r[DCS_HI:DCS_LO] == BYTE_BAD)
               || (dcs_r[DCS_HEX] && dcs_r[3])
               || (!dcs_r[3] && ({1'b0, first_r[7:0]} + {1'b0, max_r} > TBL_LAST))
               || badType;

  always_ff @(posedge mclk or negedge rstN_r) begin
    if (!rstN_r) errFlag_r <= 1'b0;
    else         errFlag_r <= errNow;
  end

  // ----------------------------------------------------------------
  // Hex byte alternation
  // ----------------------------------------------------------------
  logic [31:0]  altCnt_r;
  lpodc_phase_t phase_r;
  logic         altOn;

  assign altOn = wordEn && dcs_r[DCS_HEX] && (dcs_r[DCS_HI:DCS_LO] == BYTE_ALT);

  // Phase restarts on the low byte whenever alternation is off
  always_ff @(posedge mclk or negedge rstN_r) begin
    if (!rstN_r) begin
      altCnt_r <= 32'h0000_0000;
      phase_r  <= PH_LOW;
    end else if (!altOn) begin
      altCnt_r <= 32'h0000_0000;
      phase_r  <= PH_LOW;
    end else if (altCnt_r >= ALT_CYCLES - 1) begin
      altCnt_r <= 32'h0000_0000;
      unique case (phase_r)
        PH_LOW:  phase_r <= PH_HIGH;
        PH_HIGH: phase_r <= PH_LOW;
      endcase
    end else begin
      altCnt_r <= altCnt_r + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // Panel content
  // ----------------------------------------------------------------
  logic [15:0] win [4];
  logic [7:0]  shownByte;
  logic        showHigh;
  logic [31:0] p0Nxt;
  logic [31:0] p1Nxt;
  logic [31:0] p2Nxt;

  always_comb begin
    for (int k = 0; k < 4; k++) begin
      if (dcs_r[3]) begin
        win[k] = tbl_r[{cur_r[1:0], 2'(k)}];
      end else begin
        win[k] = tbl_r[4'(first_r[3:0] + wrapAdd(cur_r, 2'(k), max_r))];
      end
    end
  end

  assign showHigh  = (dcs_r[DCS_HI:DCS_LO] == BYTE_HI) || (altOn && phase_r == PH_HIGH);
  assign shownByte = showHigh ? win[0][15:8] : win[0][7:0];

  always_comb begin
    if (dcs_r[DCS_HEX] && !dcs_r[3]) begin
      p0Nxt = {28'h000_0000, shownByte[7:4]};
      p1Nxt = {28'h000_0000, shownByte[3:0]};
    end else begin
      p0Nxt = {win[1], win[0]};
      p1Nxt = {win[3], win[2]};
    end
    p2Nxt = {8'h00, cur_r, 16'h0000};
    if (errFlag_r) begin
      p0Nxt[15:0] = 16'hffff;
    end
  end

  always_ff @(posedge mclk or negedge rstN_r) begin
    if (!rstN_r) begin
      panel0      <= 32'h0000_0000;
      panel1      <= 32'h0000_0000;
      panel2      <= 32'h0000_0000;
      objWordAddr <= 16'h0000;
    end else if (wordEn) begin
      panel0      <= p0Nxt;
      panel1      <= p1Nxt;
      panel2      <= p2Nxt;
      objWordAddr <= first_r + {8'h00, cur_r};
    end else begin
      panel0      <= 32'h0000_0000;
      panel1      <= 32'h0000_0000;
      panel2      <= 32'h0000_0000;
      objWordAddr <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Status LEDs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstN_r) begin
    if (!rstN_r) begin
      batteryLed  <= 1'b0;
      wordModeLed <= 1'b0;
    end else begin
      batteryLed  <= batteryFault && !ctrl_r[CB_BAT_INH];
      wordModeLed <= wordEn;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstN_r);

  a_bat_led_gate: assert property (
    ctrl_r[CB_BAT_INH] |=> !batteryLed)
    else $error("battery LED lit while inhibited");

  a_word_led_on: assert property (
    wordEn && $past(wordEn) |-> wordModeLed)
    else $error("word-mode LED off in word mode");

  a_err_panel_lit: assert property (
    wordEn && errFlag_r |=> panel0[15:0] == 16'hffff)
    else $error("error not shown on first panel");

  a_err_byte_sel: assert property (
    dcs_r[DCS_HI:DCS_LO] == BYTE_BAD |=> errFlag_r)
    else $error("prohibited byte select not flagged");

  a_err_hex_bit: assert property (
    dcs_r[DCS_HEX] && dcs_r[3] |=> errFlag_r)
    else $error("hex base on bit object not flagged");

  a_idx_step_up: assert property (
    wordEn && mainStep && !wrHit(OFS_IDX) && !dcs_r[DCS_DOWN] && cur_r < limit
      |=> cur_r == $past(cur_r) + 8'h01)
    else $error("index did not step up");

  a_idx_wrap_down: assert property (
    wordEn && mainStep && !wrHit(OFS_IDX) && dcs_r[DCS_DOWN] && cur_r == 8'h00
      |=> cur_r == $past(limit))
    else $error("index did not wrap to maximum");

  a_step_single: assert property (
    mainStep |=> !mainStep)
    else $error("step event longer than one cycle");

  a_idx_shown: assert property (
    wordEn |=> panel2[23:16] == $past(cur_r))
    else $error("current index not on third panel");

endmodule : lpodc_top

`default_nettype wire

/* tb/lpodc_panel_model.sv */
// Push buttons, discrete inputs and battery sense facing the controller
`timescale 1ns/1ps
`default_nettype none
module lpodc_panel_model (
  // Clock
  input  wire logic         mclk,
  // Lines toward the controller
  output var  logic         mainButton,
  output var  logic         busmodButton,
  output var  logic [255:0] discreteIn,
  output var  logic         batteryFault,
  // Observed event
  input  wire logic         busmodStep
);
  int stepCount;

  initial begin
    mainButton   = 1'b0;
    busmodButton = 1'b0;
    discreteIn   = '0;
    batteryFault = 1'b0;
    stepCount    = 0;
  end

  always @(posedge mclk) begin
    if (busmodStep === 1'b1) begin
      stepCount <= stepCount + 1;
    end
  end

  // ----------------------------------------------------------------
  // Line control
  // ----------------------------------------------------------------
  task automatic drive(input int src, input logic v);
    case (src)
      -1: mainButton <= v;
      -2: busmodButton <= v;
      -3: batteryFault <= v;
      default: discreteIn[src] <= v;
    endcase
  endtask : drive

  // Held several cycles so a level-sensitive step would show three times
  task automatic press(input int src);
    @(posedge mclk);
    drive(src, 1'b1);
    repeat (3) @(posedge mclk);
    drive(src, 1'b0);
    repeat (3) @(posedge mclk);
  endtask : press
endmodule : lpodc_panel_model
`default_nettype wire

/* tb/led_panel_object_display_ctrl_test.sv */
// Self-checking bench for the front-panel object display controller
`timescale 1ns/1ps
`default_nettype none
module led_panel_object_display_ctrl_test
  import lpodc_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int ALT = 8;
  localparam logic [3:0] TYPES [7] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h9, 4'ha, 4'hb};
  logic         mclk;
  logic         arst_n;
  logic         hsel;
  logic [31:0]  haddr;
  logic [1:0]   htrans;
  logic         hwrite;
  logic [2:0]   hsize;
  logic [31:0]  hwdata;
  logic         hreadyout;
  logic [31:0]  hrdata;
  logic         hresp;
  logic         mainButton;
  logic         busmodButton;
  logic [255:0] discreteIn;
  logic         batteryFault;
  logic         batteryLed;
  logic         wordModeLed;
  logic [31:0]  panel0;
  logic [31:0]  panel1;
  logic [31:0]  panel2;
  logic         busmodStep;
  logic [15:0]  objWordAddr;
  logic         seenLo;
  logic         seenHi;
  int           bad_count;
  int           checks_done;
  int           cycles;
  int           base;

  lpodc_top #(.ALT_CYCLES(ALT)) u_dut (
    .mclk(mclk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .mainButton(mainButton),
    .busmodButton(busmodButton), .discreteIn(discreteIn), .batteryFault(batteryFault),
    .batteryLed(batteryLed), .wordModeLed(wordModeLed), .panel0(panel0),
    .panel1(panel1), .panel2(panel2), .busmodStep(busmodStep),
    .objWordAddr(objWordAddr)
  );

  lpodc_panel_model u_panel (
    .mclk(mclk), .mainButton(mainButton), .busmodButton(busmodButton),
    .discreteIn(discreteIn), .batteryFault(batteryFault), .busmodStep(busmodStep)
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function automatic logic [15:0] tv(input int i);
    tv = {4'(15 - i), 4'(i), 4'(i), 4'(15 - i)};
  endfunction : tv

  task automatic complete_run();
    $display("checks %0d bad %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic bus(input logic [7:0] a, input logic w, input logic [15:0] d,
                     output logic [31:0] q);
    @(posedge mclk);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= SZ_WORD;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {16'h0000, d};
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    logic [31:0] q;
    bus(a, 1'b0, 16'h0000, q);
    check(q[31:16], 16'h0000);
    check(q[15:0], e);
    check(16'(hresp), 16'h0000);
  endtask : rdchk

  task automatic settle();
    repeat (4) @(posedge mclk);
  endtask : settle

  task automatic hexchk(input logic [7:0] e);
    check({8'h00, panel0[3:0], panel1[3:0]}, {8'h00, e});
  endtask : hexchk

  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h0;
    hwdata = '0;
    arst_n = 1'b0;
    bad_count = 0;
    checks_done = 0;
    cycles = 0;
    repeat (10) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rdchk(OFS_CTRL, 16'h0000);
    rdchk(OFS_MAIN_ADDR, 16'h001a);
    rdchk(OFS_BUS_ADDR, 16'h001b);
    rdchk(OFS_DCS, 16'h00d0);
    rdchk(OFS_IDX, 16'h0f00);
    rdchk(OFS_FIRST, 16'h0000);
    rdchk(8'h30, 16'h0000);
    u_panel.drive(-3, 1'b1);
    settle();
    check(16'(batteryLed), 16'h0001);
    wr(OFS_CTRL, 16'h0004);
    settle();
    check(16'(batteryLed), 16'h0000);
    u_panel.drive(-3, 1'b0);
    for (int i = 0; i < 16; i++) begin
      wr(8'(64 + 4 * i), tv(i));
    end
    wr(OFS_IDX, 16'h0707);
    wr(OFS_FIRST, 16'h0008);
    wr(OFS_DCS, 16'h0050);
    wr(OFS_CTRL, 16'h0008);
    settle();
    check(16'(wordModeLed), 16'h0001);
    check(panel2[31:16], 16'h0007);
    check(objWordAddr, 16'h000f);
    hexchk(8'hf0);
    u_panel.press(-1);
    settle();
    rdchk(OFS_IDX, 16'h0700);
    check(objWordAddr, 16'h0008);
    hexchk(8'h87);
    wr(OFS_DCS, 16'h0090);
    settle();
    hexchk(8'h78);
    wr(OFS_DCS, 16'h00b0);
    u_panel.press(-1);
    settle();
    rdchk(OFS_IDX, 16'h0707);
    hexchk(8'h0f);
    wr(OFS_DCS, 16'h00d0);
    seenLo = 1'b0;
    seenHi = 1'b0;
    repeat (40) begin
      @(posedge mclk);
      seenLo |= ({panel0[3:0], panel1[3:0]} === 8'hf0);
      seenHi |= ({panel0[3:0], panel1[3:0]} === 8'h0f);
    end
    check({14'h0000, seenLo, seenHi}, 16'h0003);
    wr(OFS_IDX, 16'h0705);
    wr(OFS_DCS, 16'h00c0);
    settle();
    check(panel0[15:0], tv(13));
    check(panel0[31:16], tv(14));
    check(panel1[15:0], tv(15));
    check(panel1[31:16], tv(8));
    foreach (TYPES[k]) begin
      wr(OFS_DCS, {12'h00c, TYPES[k]});
      settle();
      rdchk(OFS_DCS, {12'h00c, TYPES[k]});
    end
    wr(OFS_DCS, 16'h0010);
    settle();
    rdchk(OFS_DCS, 16'h8010);
    check(panel0[15:0], 16'hffff);
    wr(OFS_DCS, 16'h00d8);
    settle();
    rdchk(OFS_DCS, 16'h80d8);
    wr(OFS_DCS, 16'h00d0);
    wr(OFS_IDX, 16'h0f00);
    settle();
    rdchk(OFS_DCS, 16'h80d0);
    wr(OFS_IDX, 16'h0700);
    settle();
    rdchk(OFS_DCS, 16'h00d0);
    wr(OFS_CTRL, 16'h0009);
    u_panel.press(-1);
    u_panel.press(26);
    wr(OFS_MAIN_ADDR, 16'h0005);
    u_panel.press(5);
    settle();
    rdchk(OFS_IDX, 16'h0702);
    base = u_panel.stepCount;
    wr(OFS_CTRL, 16'h0008);
    u_panel.press(-2);
    settle();
    check(16'(u_panel.stepCount - base), 16'h0001);
    wr(OFS_CTRL, 16'h000a);
    u_panel.press(-2);
    u_panel.press(27);
    settle();
    check(16'(u_panel.stepCount - base), 16'h0002);
    wr(OFS_CTRL, 16'h0000);
    settle();
    check(16'(wordModeLed), 16'h0000);
    complete_run();
  end
endmodule : led_panel_object_display_ctrl_test
`default_nettype wire
